// ### dsol_host_model.sv
// controller-side model driving the low-active interface lines
`timescale 1ns/1ps
module dsol_host_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rnd_en,
	input wire logic force_sel,
	input wire logic sel_val,
	output logic unit_select_n,
	output logic head_engage_n,
	output logic activity_req_n,
	output logic write_gate_n,
	output logic erase_gate_n
);
	// requests asserted by driving low; the four gates idle high outside traffic, unit select forced from sel_val or random
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			unit_select_n <= 1'b1;
			{head_engage_n, activity_req_n, write_gate_n, erase_gate_n} <= 4'hf;
		end else begin
			{head_engage_n, activity_req_n, write_gate_n, erase_gate_n} <= rnd_en ? 4'($urandom) : 4'hf;
			unit_select_n <= force_sel ? !sel_val : 1'($urandom);
		end
	end
endmodule // dsol_host_model

// ### dsol_params.svh
// option codes and reset values for the drive status option logic
`ifndef DSOL_PARAMS_SVH
`define DSOL_PARAMS_SVH

// ----------------------------------------------------------------
// lamp option codes
// ----------------------------------------------------------------
`define DSOL_LAMP_SELECT 2'h0
`define DSOL_LAMP_SEL_OR_REQ 2'h1
`define DSOL_LAMP_HEAD_OR_REQ 2'h2
`define DSOL_LAMP_REQ_ONLY 2'h3

// ----------------------------------------------------------------
// reset values of outputs (low-active lines idle high)
// ----------------------------------------------------------------
`define DSOL_RST_IDLE_HIGH 1'b1
`define DSOL_RST_IDLE_LOW 1'b0

`endif

// ### dsol_pkg.sv
// types for the drive status option logic
package dsol_pkg;
	// state of the media-swap tracker
	typedef enum logic [1:0] {
		DSOL_SW_SELECTED,
		DSOL_SW_DESELECTED,
		DSOL_SW_REMOVED,
		DSOL_SW_SWAPPED
	} dsol_swap_t;
endpackage

// ### dsol_swap_track.sv
// media swap detector: deselect, removal, new insert before reselect
`timescale 1ns/1ps
module dsol_swap_track (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic selected,
	input wire logic door_open,
	input wire logic media_present,
	output logic swap_seen
);
	dsol_pkg::dsol_swap_t state;
	dsol_pkg::dsol_swap_t next_state;
	logic next_swap_seen;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_swap_seen = swap_seen;
		case (state)
			dsol_pkg::DSOL_SW_SELECTED: begin
				if (!selected) begin
					next_state = dsol_pkg::DSOL_SW_DESELECTED;
				end
			end
			dsol_pkg::DSOL_SW_DESELECTED: begin
				if (selected) begin
					next_state = dsol_pkg::DSOL_SW_SELECTED;
				end else if (door_open && !media_present) begin
					next_state = dsol_pkg::DSOL_SW_REMOVED;
				end
			end
			dsol_pkg::DSOL_SW_REMOVED: begin
				if (selected) begin
					next_state = dsol_pkg::DSOL_SW_SELECTED;
				end else if (media_present) begin
					next_state = dsol_pkg::DSOL_SW_SWAPPED;
				end
			end
			dsol_pkg::DSOL_SW_SWAPPED: begin
				// flag raised at reselection, held while selected
				if (selected) begin
					next_swap_seen = 1'b1;
					next_state = dsol_pkg::DSOL_SW_SELECTED;
				end
			end
			default: begin
				next_state = dsol_pkg::DSOL_SW_SELECTED;
			end
		endcase
		// flag clears at the next deselection
		if (state == dsol_pkg::DSOL_SW_SELECTED && !selected) begin
			next_swap_seen = 1'b0;
		end
		if (!clk_en) begin
			next_state = state;
			next_swap_seen = swap_seen;
		end
	end

	// register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= dsol_pkg::DSOL_SW_SELECTED;
			swap_seen <= 1'b0;
		end else begin
			state <= next_state;
			swap_seen <= next_swap_seen;
		end
	end
endmodule // dsol_swap_track

// ### dsol_sync_flop.sv
// one registered output bit with clock enable and reset value
`timescale 1ns/1ps
module dsol_sync_flop #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic d,
	output logic q
);
	logic next_q;

	// hold while disabled
	always_comb begin
		next_q = clk_en ? d : q;
	end

	// register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= RST_VAL;
		end else begin
			q <= next_q;
		end
	end
endmodule // dsol_sync_flop

// ### dsol_top.sv
// top of the drive status option logic: index, lamp, lock, protect, media
// Operation
// R1: index on shared line only while selected
// R2: radial option: index always on alternate output
// R3: default lamp follows unit select
// R4: door lock needs select and ready
// R5: activity request inputs are active low
// R6: option one: lamp from select or request
// R7: option two: lamp from head engage or request
// R8: option three: lamp from request only
// R9: latch option holds door lock after activation
// R10: latch option may take request from select
// R11: override reports protection, writes still allowed
// R12: no override: report and block writes
// R13: swap output low after medium exchanged unselected
// R14: sides output low for double-sided media
// R15: options captured once, static while running
`timescale 1ns/1ps
`include "dsol_params.svh"
module dsol_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// interface inputs, low active
	input wire logic unit_select_n,
	input wire logic head_engage_n,
	input wire logic activity_req_n,
	input wire logic write_gate_n,
	input wire logic erase_gate_n,
	// drive internal sense
	input wire logic index_pulse,
	input wire logic ready,
	input wire logic wp_sensed,
	input wire logic door_open,
	input wire logic media_present,
	input wire logic media_two_sided,
	// option straps
	input wire logic opt_radial_index,
	input wire logic [1:0] opt_lamp,
	input wire logic opt_door_latch,
	input wire logic opt_latch_from_select,
	input wire logic opt_wp_override,
	input wire logic opt_swap_enable,
	input wire logic opt_sides_enable,
	// outputs
	output logic index_n,
	output logic index_alt_n,
	output logic lamp_on,
	output logic door_lock,
	output logic write_protect_n,
	output logic write_enable,
	output logic erase_enable,
	output logic media_swap_n,
	output logic media_sides_n
);
	// ----------------------------------------------------------------
	// option capture after reset release
	// ----------------------------------------------------------------
	logic opt_valid;
	logic cfg_radial;
	logic [1:0] cfg_lamp;
	logic cfg_latch;
	logic cfg_latch_sel;
	logic cfg_wp_ovr;
	logic cfg_swap;
	logic cfg_sides;
	logic next_opt_valid;
	logic next_cfg_radial;
	logic [1:0] next_cfg_lamp;
	logic next_cfg_latch;
	logic next_cfg_latch_sel;
	logic next_cfg_wp_ovr;
	logic next_cfg_swap;
	logic next_cfg_sides;

	// straps sampled once on first enabled edge, then frozen
	always_comb begin
		next_opt_valid = opt_valid;
		next_cfg_radial = cfg_radial;
		next_cfg_lamp = cfg_lamp;
		next_cfg_latch = cfg_latch;
		next_cfg_latch_sel = cfg_latch_sel;
		next_cfg_wp_ovr = cfg_wp_ovr;
		next_cfg_swap = cfg_swap;
		next_cfg_sides = cfg_sides;
		if (clk_en && !opt_valid) begin // [R15]
			next_opt_valid = 1'b1;
			next_cfg_radial = opt_radial_index;
			next_cfg_lamp = opt_lamp;
			next_cfg_latch = opt_door_latch;
			next_cfg_latch_sel = opt_latch_from_select;
			next_cfg_wp_ovr = opt_wp_override;
			next_cfg_swap = opt_swap_enable;
			next_cfg_sides = opt_sides_enable;
		end
	end

	// register the captured straps
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			opt_valid <= 1'b0;
			cfg_radial <= 1'b0;
			cfg_lamp <= `DSOL_LAMP_SELECT;
			cfg_latch <= 1'b0;
			cfg_latch_sel <= 1'b0;
			cfg_wp_ovr <= 1'b0;
			cfg_swap <= 1'b0;
			cfg_sides <= 1'b0;
		end else begin
			opt_valid <= next_opt_valid;
			cfg_radial <= next_cfg_radial;
			cfg_lamp <= next_cfg_lamp;
			cfg_latch <= next_cfg_latch;
			cfg_latch_sel <= next_cfg_latch_sel;
			cfg_wp_ovr <= next_cfg_wp_ovr;
			cfg_swap <= next_cfg_swap;
			cfg_sides <= next_cfg_sides;
		end
	end

	// ----------------------------------------------------------------
	// input decode
	// ----------------------------------------------------------------
	logic sel;
	logic head;
	logic req;
	logic act_req;

	// low level means asserted
	assign sel = !unit_select_n; // [R5]
	assign head = !head_engage_n; // [R5]
	assign req = !activity_req_n; // [R5]
	// latch option may use select as activity request
	assign act_req = (cfg_latch && cfg_latch_sel) ? sel : req; // [R10]

	// ----------------------------------------------------------------
	// door lock latch
	// ----------------------------------------------------------------
	logic lock_held;
	logic next_lock_held;

	// latch sets on activation, releases when select drops
	always_comb begin
		next_lock_held = lock_held;
		if (clk_en) begin
			if (!cfg_latch || !opt_valid) begin
				next_lock_held = 1'b0;
			end else if (sel && ready && act_req) begin
				next_lock_held = 1'b1; // [R9]
			end else if (!sel) begin
				next_lock_held = 1'b0;
			end
		end
	end

	// register latch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_held <= 1'b0;
		end else begin
			lock_held <= next_lock_held;
		end
	end

	// ----------------------------------------------------------------
	// media swap tracker
	// ----------------------------------------------------------------
	logic swap_seen;

	dsol_swap_track u_swap (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.selected(sel),
		.door_open(door_open),
		.media_present(media_present),
		.swap_seen(swap_seen)
	);

	// ----------------------------------------------------------------
	// output terms
	// ----------------------------------------------------------------
	logic lamp_d;
	logic lock_d;
	logic write_block;
	logic index_d;
	logic index_alt_d;
	logic wp_d;
	logic wr_d;
	logic er_d;
	logic swap_d;
	logic sides_d;

	// lamp source by option
	always_comb begin
		case (cfg_lamp)
			`DSOL_LAMP_SELECT: lamp_d = sel; // [R3]
			`DSOL_LAMP_SEL_OR_REQ: lamp_d = sel || req; // [R6]
			`DSOL_LAMP_HEAD_OR_REQ: lamp_d = head || req; // [R7]
			`DSOL_LAMP_REQ_ONLY: lamp_d = req; // [R8]
			default: lamp_d = sel;
		endcase
		if (cfg_latch) begin
			lamp_d = lamp_d || lock_held;
		end
	end

	// lock, index, protection and media terms
	always_comb begin
		lock_d = (sel && ready) || lock_held; // [R4] [R9]
		index_d = !(sel && index_pulse); // [R1]
		index_alt_d = cfg_radial ? !index_pulse : `DSOL_RST_IDLE_HIGH; // [R2]
		write_block = wp_sensed && !cfg_wp_ovr; // [R11] [R12]
		wp_d = !(sel && wp_sensed); // [R11] [R12]
		wr_d = sel && !write_gate_n && !write_block; // [R12]
		er_d = sel && !erase_gate_n && !write_block; // [R12]
		swap_d = !(cfg_swap && sel && swap_seen); // [R13]
		sides_d = cfg_sides ? !media_two_sided : `DSOL_RST_IDLE_HIGH; // [R14]
		if (!opt_valid) begin
			lock_d = 1'b0;
			index_alt_d = `DSOL_RST_IDLE_HIGH;
			swap_d = `DSOL_RST_IDLE_HIGH;
			sides_d = `DSOL_RST_IDLE_HIGH;
			wr_d = 1'b0;
			er_d = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// shared index line, idles high
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_HIGH)) u_idx (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(index_d),
		.q(index_n)
	);
	// radial index line, idles high
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_HIGH)) u_idx_alt (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(index_alt_d),
		.q(index_alt_n)
	);
	// activity lamp, dark in reset
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_LOW)) u_lamp (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(lamp_d),
		.q(lamp_on)
	);
	// door solenoid, released in reset
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_LOW)) u_lock (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(lock_d),
		.q(door_lock)
	);
	// protection report, idles high
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_HIGH)) u_wp (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(wp_d),
		.q(write_protect_n)
	);
	// write current permit, off in reset
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_LOW)) u_wr (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(wr_d),
		.q(write_enable)
	);
	// erase permit, off in reset
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_LOW)) u_er (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(er_d),
		.q(erase_enable)
	);
	// media swap line, idles high
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_HIGH)) u_swp (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(swap_d),
		.q(media_swap_n)
	);
	// media sides line, idles high
	dsol_sync_flop #(.RST_VAL(`DSOL_RST_IDLE_HIGH)) u_sides (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(sides_d),
		.q(media_sides_n)
	);
endmodule // dsol_top

// ### dsol_top_sva.sv
// assertions on the ports of the drive status option logic
`timescale 1ns/1ps
`include "dsol_params.svh"
module dsol_top_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic unit_select_n,
	input wire logic head_engage_n,
	input wire logic activity_req_n,
	input wire logic write_gate_n,
	input wire logic erase_gate_n,
	input wire logic index_pulse,
	input wire logic ready,
	input wire logic wp_sensed,
	input wire logic media_two_sided,
	input wire logic opt_radial_index,
	input wire logic [1:0] opt_lamp,
	input wire logic opt_door_latch,
	input wire logic opt_latch_from_select,
	input wire logic opt_wp_override,
	input wire logic opt_sides_enable,
	input wire logic index_n,
	input wire logic index_alt_n,
	input wire logic lamp_on,
	input wire logic door_lock,
	input wire logic write_protect_n,
	input wire logic write_enable,
	input wire logic erase_enable,
	input wire logic media_swap_n,
	input wire logic media_sides_n
);
	logic seen;
	logic next_seen;
	logic ok;
	logic sel;
	logic lamp_exp;
	// an enabled edge has passed, straps are captured
	assign next_seen = seen | clk_en;
	assign ok = seen & clk_en;
	assign sel = !unit_select_n;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) seen <= 1'b0;
		else seen <= next_seen;
	end
	// lamp source for each strap setting
	always_comb begin
		case (opt_lamp)
			`DSOL_LAMP_SELECT: lamp_exp = sel;
			`DSOL_LAMP_SEL_OR_REQ: lamp_exp = sel | !activity_req_n;
			`DSOL_LAMP_HEAD_OR_REQ: lamp_exp = !head_engage_n | !activity_req_n;
			default: lamp_exp = !activity_req_n;
		endcase
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// latch activation: select, ready and the activity request together
	sequence s_locked;
		ok && opt_door_latch && sel && ready && (opt_latch_from_select || !activity_req_n);
	endsequence
	sequence s_away;
		(ok && !sel) [*3];
	endsequence
	a_index_shared: assert property (
		$past(ok) && !opt_radial_index |-> index_n == !$past(sel && index_pulse))
		else $error("shared index wrong");
	a_index_radial: assert property (
		$past(ok) |-> index_alt_n == !(opt_radial_index && $past(index_pulse)))
		else $error("radial index wrong");
	a_lamp_source: assert property (
		$past(ok) && !opt_door_latch |-> lamp_on == $past(lamp_exp))
		else $error("lamp source wrong");
	a_lock_plain: assert property (
		$past(ok) && !opt_door_latch |-> door_lock == $past(sel && ready))
		else $error("door lock wrong");
	a_lock_held: assert property (s_locked |=> door_lock [*2])
		else $error("latched lock dropped");
	a_wp_report: assert property (
		$past(ok) |-> write_protect_n == !$past(sel && wp_sensed))
		else $error("protect report wrong");
	a_wp_block: assert property (
		$past(ok) && !opt_wp_override && $past(wp_sensed) |-> !write_enable && !erase_enable)
		else $error("protected write allowed");
	a_write_gate: assert property (
		$past(ok) |-> write_enable == $past(sel && !write_gate_n && !(wp_sensed && !opt_wp_override))
		&& erase_enable == $past(sel && !erase_gate_n && !(wp_sensed && !opt_wp_override)))
		else $error("write permit wrong");
	a_sides_level: assert property (
		$past(ok) |-> media_sides_n == !(opt_sides_enable && $past(media_two_sided)))
		else $error("sides output wrong");
	a_swap_clear: assert property (s_away |=> media_swap_n)
		else $error("swap flag stuck");
endmodule // dsol_top_sva
bind dsol_top dsol_top_sva i_dsol_top_sva (.*);

// ### tb_top.sv
// testbench for the drive status option logic
`timescale 1ns/1ps
`include "dsol_params.svh"
module tb_top;
	logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, index_pulse = 1'b0, ready = 1'b0;
	logic wp_sensed = 1'b0, door_open = 1'b0, media_present = 1'b1, media_two_sided = 1'b0;
	logic opt_radial_index = 1'b0, opt_door_latch = 1'b0, opt_latch_from_select = 1'b0;
	logic opt_wp_override = 1'b0, opt_swap_enable = 1'b1, opt_sides_enable = 1'b0;
	logic [1:0] opt_lamp = 2'h0;
	logic rnd_en = 1'b0, force_sel = 1'b1, sel_val = 1'b0, seen = 1'b0;
	logic unit_select_n, head_engage_n, activity_req_n, write_gate_n, erase_gate_n;
	logic index_n, index_alt_n, lamp_on, door_lock, write_protect_n, write_enable;
	logic erase_enable, media_swap_n, media_sides_n;
	logic [7:0] exp_q[$];
	logic [7:0] e_lv, got_lv;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	dsol_top i_dsol_top (.*);
	dsol_host_model i_dsol_host_model (.clk, .reset_n, .rnd_en, .force_sel, .sel_val,
		.unit_select_n, .head_engage_n, .activity_req_n, .write_gate_n, .erase_gate_n);
	always #50 clk = ~clk;
	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] exp_vec();
		logic sel;
		logic lamp;
		sel = !unit_select_n;
		case (opt_lamp)
			`DSOL_LAMP_SELECT: lamp = sel;
			`DSOL_LAMP_SEL_OR_REQ: lamp = sel | !activity_req_n;
			`DSOL_LAMP_HEAD_OR_REQ: lamp = !head_engage_n | !activity_req_n;
			default: lamp = !activity_req_n;
		endcase
		return {!(sel & index_pulse) | opt_radial_index, !(opt_radial_index & index_pulse),
			lamp, sel & ready, !(sel & wp_sensed), !(opt_sides_enable & media_two_sided),
			sel & !write_gate_n & !(wp_sensed & !opt_wp_override),
			sel & !erase_gate_n & !(wp_sensed & !opt_wp_override)};
	endfunction
	// note the expected levels of each enabled edge after strap capture while the door latch strap is clear
	always @(posedge clk) begin
		if (!reset_n) seen = 1'b0;
		else if (clk_en) begin
			if (seen && !opt_door_latch) exp_q.push_back(exp_vec());
			seen = 1'b1;
		end
	end
	// compare the levels that the edge produced, drop notes cut by reset
	always @(negedge clk) begin
		got_lv = {index_n | opt_radial_index, index_alt_n, lamp_on, door_lock, write_protect_n,
			media_sides_n, write_enable, erase_enable};
		if (!reset_n) begin
			exp_q.delete();
		end else if (exp_q.size() > 0) begin
			e_lv = exp_q.pop_front();
			chk("ix", 8'(e_lv[7:4]), 8'(got_lv[7:4]));
			chk("wp", 8'(e_lv[3:0]), 8'(got_lv[3:0]));
		end
	end
	// random drive sense and clock enable, cycle ceiling last
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rnd_en) begin
			{index_pulse, ready, wp_sensed, media_two_sided} <= 4'($urandom);
			clk_en <= ($urandom % 8) != 0;
		end
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic run_cfg(logic [6:0] c, int n);
		@(posedge clk);
		{opt_door_latch, opt_latch_from_select, opt_sides_enable, opt_wp_override,
			opt_radial_index, opt_lamp} <= c;
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rnd_en <= n > 0;
		repeat (n) @(posedge clk);
		rnd_en <= 1'b0;
		@(posedge clk);
		{clk_en, ready, index_pulse} <= 3'h4;
	endtask
	task automatic step_sel(logic s, int n, string what, logic e);
		@(posedge clk);
		sel_val <= s;
		repeat (n) @(posedge clk);
		@(negedge clk);
		chk(what, 8'(e), {7'h0, what == "lock" ? door_lock : media_swap_n});
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(13));
		force_sel <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			run_cfg({2'b00, k[2], k[1], k[0] ^ k[1], k[1:0]}, 300);
		end
		run_cfg(7'h60, 300);
		force_sel <= 1'b1;
		run_cfg(7'h60, 0);
		@(posedge clk);
		ready <= 1'b1;
		step_sel(1'b1, 3, "lock", 1'b1);
		@(posedge clk);
		ready <= 1'b0;
		step_sel(1'b1, 3, "lock", 1'b1);
		step_sel(1'b0, 3, "lock", 1'b0);
		step_sel(1'b1, 4, "swap", 1'b1);
		@(posedge clk);
		sel_val <= 1'b0;
		repeat (2) @(posedge clk);
		{door_open, media_present} <= 2'b10;
		repeat (2) @(posedge clk);
		{door_open, media_present} <= 2'b01;
		repeat (2) @(posedge clk);
		step_sel(1'b1, 3, "swap", 1'b0);
		step_sel(1'b0, 3, "swap", 1'b1);
		step_sel(1'b1, 4, "swap", 1'b1);
		// strap moved while running must not change the lamp source
		@(posedge clk);
		opt_lamp <= 2'h3;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("strap", 8'h01, {7'h0, lamp_on});
		end_sim();
	end
endmodule // tb_top
